// >>> rtl/tmc_mode_ctrl.sv
// Chip operating-mode controller: block power enables, digital pin drive
// and transmit bit mapping.
// Assumes a register core on CLK_I presents staged configuration and the
// serial output bit; pins and the link clock arrive asynchronously.
`include "tmc_defines.svh"

module tmc_mode_ctrl
    import tmc_pkg::*;
#(
    parameter int FIFO_WIDTH = `TMC_FIFO_WIDTH,
    parameter int FIFO_DEPTH = `TMC_FIFO_DEPTH
)
(
    // Clock and reset
    input  wire logic                    CLK_I,
    input  wire logic                    RST_B_I,
    // Staged configuration from the register core
    input  wire logic [`TMC_MODE_W-1:0]  CFG_CHIP_MODE_I,
    input  wire logic [`TMC_DMODE_W-1:0] CFG_DATA_MODE_I,
    input  wire logic                    CFG_REFERENCE_CLOCK_OUTPUT_EN_I,
    input  wire logic [`TMC_DIV_W-1:0]   CFG_REFERENCE_CLOCK_OUTPUT_DIV_I,
    input  wire logic                    CFG_LOCK_OUT_EN_I,
    input  wire logic [`TMC_DEV_W-1:0]   CFG_DEVIATION_I,
    input  wire logic                    CFG_OOK_I,
    input  wire logic                    CFG_INT_TX_SRC_I,
    input  wire logic                    CFG_IRQ_A_EN_I,
    input  wire logic                    CFG_IRQ_A_UNMASK_I,
    input  wire logic                    CFG_IRQ_A_HIGH_I,
    input  wire logic                    CFG_IRQ_B_EN_I,
    input  wire logic                    CFG_IRQ_B_UNMASK_I,
    input  wire logic                    CFG_IRQ_B_HIGH_I,
    // Asynchronous pins
    input  wire logic                    CONFIG_PORT_SELECT_N_I,
    input  wire logic                    FIFO_PORT_SELECT_N_I,
    input  wire logic                    BIT_CLK_I,
    input  wire logic                    DATA_I,
    input  wire logic                    SYNTH_LOCK_I,
    // Same-clock sources and the FIFO ready output
    input  wire logic                    SDO_BIT_I,
    input  wire logic                    IRQ_A_EVENT_I,
    input  wire logic                    IRQ_B_EVENT_I,
    input  wire logic                    DEMOD_BIT_I,
    input  wire logic                    DEMOD_VALID_I,
    input  wire logic                    INT_TX_BIT_I,
    input  wire logic                    INT_TX_VALID_I,
    input  wire logic                    MOD_BIT_STROBE_I,
    output logic                         FIFO_IN_READY_O,
    // Block power enables and modulator controls
    output logic                         STANDBY_EN_O,
    output logic                         REFERENCE_CLOCK_OUTPUT_BLOCK_EN_O,
    output logic                         SYNTH_EN_O,
    output logic                         RX_CHAIN_EN_O,
    output logic                         TX_CHAIN_EN_O,
    output logic                         PA_EN_O,
    output logic                         PA_CHOKE_EN_O,
    output logic                         IQ_PHASE_PLUS_O,
    output logic [`TMC_DEV_W-1:0]        DEVIATION_VALUE_O,
    output logic                         SERIAL_DATA_PORT_EN_O,
    output logic [`TMC_MODE_W-1:0]       CHIP_MODE_O,
    // Serial port selection and output pin
    output logic                         CONFIG_PORT_ACTIVE_O,
    output logic                         FIFO_PORT_ACTIVE_O,
    output logic                         SDO_O,
    output logic                         SDO_OE_O,
    // Interrupt, clock, lock and data pins
    output logic                         INTERRUPT_LINE_A_O,
    output logic                         INTERRUPT_LINE_A_OE_O,
    output logic                         INTERRUPT_LINE_B_O,
    output logic                         INTERRUPT_LINE_B_OE_O,
    output logic                         REFERENCE_CLOCK_OUTPUT_O,
    output logic                         REFERENCE_CLOCK_OUTPUT_OE_O,
    output logic                         SYNTH_LOCK_OUTPUT_O,
    output logic                         SYNTH_LOCK_OUTPUT_OE_O,
    output logic                         DATA_O,
    output logic                         DATA_OE_O
);

    // Synchronised pins: selects reset high (deselected)
    logic [4:0] pins_s;
    logic       csc_n_s;
    logic       csd_n_s;
    logic       bclk_s;
    logic       data_s;
    logic       lock_s;

    tmc_sync #(
        .WIDTH   (5),
        .RST_VAL (64'h3)
    ) u_sync (
        .clk_i   (CLK_I),
        .rst_b_i (RST_B_I),
        .async_i ({SYNTH_LOCK_I, DATA_I, BIT_CLK_I,
                   FIFO_PORT_SELECT_N_I, CONFIG_PORT_SELECT_N_I}),
        .sync_o  (pins_s)
    );

    assign csc_n_s = pins_s[0];
    assign csd_n_s = pins_s[1];
    assign bclk_s  = pins_s[2];
    assign data_s  = pins_s[3];
    assign lock_s  = pins_s[4];

    // Applied configuration
    tmc_chip_mode_e             mode_q;
    tmc_data_mode_e             dmode_q;
    logic                       reference_clock_output_en_q;
    logic [`TMC_DIV_W-1:0]      div_q;
    logic                       lock_en_q;
    logic [`TMC_DEV_W-1:0]      dev_q;
    logic                       ook_q;
    logic                       int_src_q;
    logic [1:0]                 irq_en_q;
    logic [1:0]                 irq_high_q;
    logic                       csc_prev_q;
    logic                       bclk_prev_q;

    // Edge detection on synchronised levels
    wire logic cfg_apply = csc_n_s & ~csc_prev_q;
    wire logic bclk_rise = bclk_s & ~bclk_prev_q;
    wire logic bclk_fall = ~bclk_s & bclk_prev_q;

    // Unused codes above transmit fall back to sleep, the safe state
    wire logic           cfg_mode_ok = CFG_CHIP_MODE_I <= `TMC_MODE_MAX;
    wire tmc_chip_mode_e cfg_mode    = cfg_mode_ok ? tmc_chip_mode_e'(CFG_CHIP_MODE_I)
                                                   : TMC_SLEEP;
    wire logic           cfg_dmode_ok = CFG_DATA_MODE_I <= 2'h2;
    wire tmc_data_mode_e cfg_dmode    = cfg_dmode_ok ? tmc_data_mode_e'(CFG_DATA_MODE_I)
                                                     : TMC_BUFFERED;

    // Configuration is taken only when the config select is released
    always_ff @(posedge CLK_I)
    begin
        if (!RST_B_I)
        begin
            mode_q      <= TMC_SLEEP;
            dmode_q     <= TMC_CONTINUOUS;
            reference_clock_output_en_q <= `TMC_REFERENCE_CLOCK_OUTPUT_RST;
            div_q       <= `TMC_DIV_RST;
            lock_en_q   <= 1'b0;
            dev_q       <= `TMC_DEV_RST;
            ook_q       <= 1'b0;
            int_src_q   <= 1'b0;
            irq_en_q    <= 2'b00;
            irq_high_q  <= 2'b00;
        end
        else if (cfg_apply)
        begin
            mode_q      <= cfg_mode;
            dmode_q     <= cfg_dmode;
            reference_clock_output_en_q <= CFG_REFERENCE_CLOCK_OUTPUT_EN_I;
            div_q       <= CFG_REFERENCE_CLOCK_OUTPUT_DIV_I;
            lock_en_q   <= CFG_LOCK_OUT_EN_I;
            dev_q       <= CFG_DEVIATION_I;
            ook_q       <= CFG_OOK_I;
            int_src_q   <= CFG_INT_TX_SRC_I;
            irq_en_q    <= {CFG_IRQ_B_EN_I & CFG_IRQ_B_UNMASK_I,
                            CFG_IRQ_A_EN_I & CFG_IRQ_A_UNMASK_I};
            irq_high_q  <= {CFG_IRQ_B_HIGH_I, CFG_IRQ_A_HIGH_I};
        end
    end

    // Mode decode
    wire logic awake   = mode_q != TMC_SLEEP;
    wire logic synth   = (mode_q == TMC_SYNTH) | (mode_q == TMC_RECEIVE)
                       | (mode_q == TMC_TRANSMIT);
    wire logic rx      = mode_q == TMC_RECEIVE;
    wire logic tx      = mode_q == TMC_TRANSMIT;
    wire logic contin  = dmode_q == TMC_CONTINUOUS;

    // Continuous data bypasses the serial FIFO port; others never use the pin
    wire logic pin_rx   = rx & contin;
    wire logic pin_tx   = tx & contin & ~int_src_q;
    wire logic path_on  = pin_rx | tx;

    // Interrupt lines float in sleep and in slow modes with continuous data
    wire logic irq_oe   = (rx | tx) | (awake & ~contin);

    // Selection: config select has priority
    wire logic sel_cfg  = ~csc_n_s;
    wire logic sel_fifo = csc_n_s & ~csd_n_s;
    wire logic selected = ~csc_n_s | ~csd_n_s;

    // Data buffer between the pin side and the modem side
    logic                  fifo_in_valid;
    logic [FIFO_WIDTH-1:0] fifo_in_data;
    logic                  fifo_out_valid;
    logic [FIFO_WIDTH-1:0] fifo_out_data;
    logic                  fifo_out_ready;
    logic                  tx_bit_q;

    // Source: demodulator in receive, pin or internal source in transmit
    assign fifo_in_valid  = pin_rx ? DEMOD_VALID_I
                          : pin_tx ? bclk_rise
                          : tx     ? INT_TX_VALID_I
                          : 1'b0;
    assign fifo_in_data   = pin_rx ? FIFO_WIDTH'(DEMOD_BIT_I)
                          : pin_tx ? FIFO_WIDTH'(data_s)
                          : FIFO_WIDTH'(INT_TX_BIT_I);
    // Sink: pin on link clock falls in receive, modulator strobe in transmit
    assign fifo_out_ready = pin_rx ? bclk_fall
                          : tx     ? MOD_BIT_STROBE_I
                          : 1'b0;

    // Flushed outside a data path; a switch straight between the receive and transmit paths keeps stale bits
    tmc_fifo #(
        .WIDTH       (FIFO_WIDTH),
        .DEPTH       (FIFO_DEPTH)
    ) u_fifo (
        .clk_i       (CLK_I),
        .rst_b_i     (RST_B_I),
        .flush_i     (~path_on),
        .in_valid_i  (fifo_in_valid),
        .in_data_i   (fifo_in_data),
        .in_ready_o  (FIFO_IN_READY_O),
        .out_valid_o (fifo_out_valid),
        .out_data_o  (fifo_out_data),
        .out_ready_i (fifo_out_ready)
    );

    wire logic tx_take  = tx & MOD_BIT_STROBE_I & fifo_out_valid;
    wire logic rx_shift = pin_rx & bclk_fall & fifo_out_valid;

    // Reference clock divider; half period is div_q + 1 cycles
    logic [`TMC_DIV_W-1:0] div_cnt_q;
    logic                  refclk_q;
    wire logic             clk_on  = awake & reference_clock_output_en_q;
    wire logic             div_end = div_cnt_q == div_q;

    always_ff @(posedge CLK_I)
    begin
        if (!RST_B_I || !clk_on)
        begin
            div_cnt_q <= '0;
            refclk_q  <= 1'b0;
        end
        else
        begin
            div_cnt_q <= div_end ? '0 : div_cnt_q + 1'b1;
            refclk_q  <= div_end ? ~refclk_q : refclk_q;
        end
    end

    // Transmit bit and edge history
    always_ff @(posedge CLK_I)
    begin
        if (!RST_B_I)
        begin
            tx_bit_q    <= 1'b0;
            csc_prev_q  <= 1'b1;
            bclk_prev_q <= 1'b0;
        end
        else
        begin
            tx_bit_q    <= tx_take ? fifo_out_data[0] : (tx & tx_bit_q);
            csc_prev_q  <= csc_n_s;
            bclk_prev_q <= bclk_s;
        end
    end

    // Block enables and modulator controls
    always_ff @(posedge CLK_I)
    begin
        if (!RST_B_I)
        begin
            STANDBY_EN_O          <= 1'b0;
            REFERENCE_CLOCK_OUTPUT_BLOCK_EN_O     <= 1'b0;
            SYNTH_EN_O            <= 1'b0;
            RX_CHAIN_EN_O         <= 1'b0;
            TX_CHAIN_EN_O         <= 1'b0;
            PA_EN_O               <= 1'b0;
            PA_CHOKE_EN_O         <= 1'b0;
            IQ_PHASE_PLUS_O       <= 1'b0;
            DEVIATION_VALUE_O     <= `TMC_DEV_RST;
            SERIAL_DATA_PORT_EN_O <= 1'b0;
            CHIP_MODE_O           <= '0;
        end
        else
        begin
            STANDBY_EN_O          <= awake;
            REFERENCE_CLOCK_OUTPUT_BLOCK_EN_O     <= clk_on;
            SYNTH_EN_O            <= synth;
            RX_CHAIN_EN_O         <= rx;
            TX_CHAIN_EN_O         <= tx;
            PA_EN_O               <= tx & (~ook_q | tx_bit_q);
            PA_CHOKE_EN_O         <= tx & (~ook_q | tx_bit_q);
            IQ_PHASE_PLUS_O       <= tx & ~ook_q & tx_bit_q;
            DEVIATION_VALUE_O     <= dev_q;
            SERIAL_DATA_PORT_EN_O <= awake & ~contin;
            CHIP_MODE_O           <= mode_q;
        end
    end

    // Pin drive; output enables high while driving
    always_ff @(posedge CLK_I)
    begin
        if (!RST_B_I)
        begin
            CONFIG_PORT_ACTIVE_O        <= 1'b0;
            FIFO_PORT_ACTIVE_O          <= 1'b0;
            SDO_O                       <= 1'b0;
            SDO_OE_O                    <= 1'b0;
            INTERRUPT_LINE_A_O          <= 1'b0;
            INTERRUPT_LINE_A_OE_O       <= 1'b0;
            INTERRUPT_LINE_B_O          <= 1'b0;
            INTERRUPT_LINE_B_OE_O       <= 1'b0;
            REFERENCE_CLOCK_OUTPUT_O    <= 1'b0;
            REFERENCE_CLOCK_OUTPUT_OE_O <= 1'b0;
            SYNTH_LOCK_OUTPUT_O         <= 1'b0;
            SYNTH_LOCK_OUTPUT_OE_O      <= 1'b0;
            DATA_O                      <= 1'b0;
            DATA_OE_O                   <= 1'b0;
        end
        else
        begin
            CONFIG_PORT_ACTIVE_O        <= sel_cfg;
            FIFO_PORT_ACTIVE_O          <= sel_fifo & ~contin;
            SDO_O                       <= SDO_BIT_I;
            SDO_OE_O                    <= selected;
            // Idle level is the opposite of the selected active level
            INTERRUPT_LINE_A_O          <= irq_en_q[0] & IRQ_A_EVENT_I
                                           ? irq_high_q[0] : ~irq_high_q[0];
            INTERRUPT_LINE_A_OE_O       <= irq_oe;
            INTERRUPT_LINE_B_O          <= irq_en_q[1] & IRQ_B_EVENT_I
                                           ? irq_high_q[1] : ~irq_high_q[1];
            INTERRUPT_LINE_B_OE_O       <= irq_oe;
            REFERENCE_CLOCK_OUTPUT_O    <= refclk_q;
            REFERENCE_CLOCK_OUTPUT_OE_O <= clk_on;
            SYNTH_LOCK_OUTPUT_O         <= lock_s;
            SYNTH_LOCK_OUTPUT_OE_O      <= awake & lock_en_q;
            DATA_O                      <= rx_shift ? fifo_out_data[0]
                                           : (pin_rx & DATA_O);
            DATA_OE_O                   <= pin_rx;
        end
    end

endmodule

// >>> inc/tmc_defines.svh
// Named constants for the mode and pin controller.
// Assumes inclusion by bare name from every design file that needs them.
`ifndef TMC_DEFINES_SVH
`define TMC_DEFINES_SVH

// Field widths
`define TMC_MODE_W        3
`define TMC_DMODE_W       2
`define TMC_DEV_W         8
`define TMC_DIV_W         8

// Highest chip mode code that selects a real mode
`define TMC_MODE_MAX      3'h4

// Reset values of the applied configuration
`define TMC_DEV_RST       8'h00
`define TMC_DIV_RST       8'h00
`define TMC_REFERENCE_CLOCK_OUTPUT_RST    1'b1

// Data path buffer shape
`define TMC_FIFO_WIDTH    1
`define TMC_FIFO_DEPTH    8

`endif

// >>> inc/tmc_pkg.sv
// Types shared by the mode and pin controller files.
// Assumes nothing beyond a SystemVerilog compiler.
package tmc_pkg;

    // Chip operating modes, in the order of their field codes
    typedef enum logic [2:0] {
        TMC_SLEEP,
        TMC_STANDBY,
        TMC_SYNTH,
        TMC_RECEIVE,
        TMC_TRANSMIT
    } tmc_chip_mode_e;

    // Data operating modes
    typedef enum logic [1:0] {
        TMC_CONTINUOUS,
        TMC_BUFFERED,
        TMC_PACKET
    } tmc_data_mode_e;

endpackage

// >>> rtl/tmc_sync.sv
// Two flip-flop synchroniser for a group of pin inputs.
// Assumes inputs are asynchronous to clk_i; reset is synchronous, active low.
module tmc_sync
#(
    parameter int          WIDTH   = 1,
    parameter logic [63:0] RST_VAL = 64'h0
)
(
    // Clock and reset
    input  wire logic             clk_i,
    input  wire logic             rst_b_i,
    // Pins in, synchronised out
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);

    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    generate
        if (WIDTH < 1 || WIDTH > 64)
        begin : g_bad_width
            $error("tmc_sync: WIDTH out of range");
        end
    endgenerate

    // First stage feeds only the second stage
    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i)
        begin
            meta_q <= RST_VAL[WIDTH-1:0];
            sync_q <= RST_VAL[WIDTH-1:0];
        end
        else
        begin
            meta_q <= async_i;
            sync_q <= meta_q;
        end
    end

    assign sync_o = sync_q;

endmodule

// >>> rtl/tmc_fifo.sv
// Small FIFO with a registered output word and a registered ready flag.
// Assumes one clock; flush_i empties it in one cycle.
module tmc_fifo
#(
    parameter int WIDTH = 1,
    parameter int DEPTH = 8
)
(
    // Clock and reset
    input  wire logic             clk_i,
    input  wire logic             rst_b_i,
    input  wire logic             flush_i,
    // Fill side
    input  wire logic             in_valid_i,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  in_ready_o,
    // Drain side
    output logic                  out_valid_o,
    output logic      [WIDTH-1:0] out_data_o,
    input  wire logic             out_ready_i
);

    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = AW + 1;
    localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH);

    generate
        if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1)
        begin : g_bad_shape
            $error("tmc_fifo: DEPTH must be a power of two, WIDTH positive");
        end
    endgenerate

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr_q;
    logic [AW-1:0]    rd_ptr_q;
    logic [CW-1:0]    cnt_q;
    logic [CW-1:0]    cnt_d;
    logic             ready_q;
    logic             valid_q;
    logic [WIDTH-1:0] data_q;

    // Handshake decode; the output stage refills whenever it empties
    wire logic push = in_valid_i & ready_q;
    wire logic pop  = valid_q & out_ready_i;
    wire logic load = (cnt_q != '0) & (~valid_q | pop);

    assign cnt_d = cnt_q + {{(CW-1){1'b0}}, push} - {{(CW-1){1'b0}}, load};

    // Storage has no reset; only the pointers matter
    always_ff @(posedge clk_i)
    begin
        if (push)
        begin
            mem[wr_ptr_q] <= in_data_i;
        end
    end

    // Pointers, count and flags
    always_ff @(posedge clk_i)
    begin
        if (!rst_b_i || flush_i)
        begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            cnt_q    <= '0;
            ready_q  <= 1'b1;
            valid_q  <= 1'b0;
        end
        else
        begin
            wr_ptr_q <= push ? wr_ptr_q + 1'b1 : wr_ptr_q;
            rd_ptr_q <= load ? rd_ptr_q + 1'b1 : rd_ptr_q;
            cnt_q    <= cnt_d;
            ready_q  <= cnt_d < DEPTH_C;  // Registered so full is never overrun
            valid_q  <= load | (valid_q & ~pop);
        end
    end

    // Registered read word
    always_ff @(posedge clk_i)
    begin
        if (load)
        begin
            data_q <= mem[rd_ptr_q];
        end
    end

    assign in_ready_o  = ready_q;
    assign out_valid_o = valid_q;
    assign out_data_o  = data_q;

endmodule

// >>> verif/tmc_host_model.sv
// Host side of the data pin: bit clock and data for pin-sourced transmit.
// Assumes the bench calls send; the bit clock stands still between frames.
module tmc_host_model (
    output logic BIT_CLK_O,
    output logic DATA_O
);
    timeunit 1ns;
    timeprecision 1ps;
    // Idle clock low, data at a valid level from time zero
    initial
    begin
        BIT_CLK_O = 1'b0;
        DATA_O    = 1'b1;
    end
    // One frame, top bit first; data settles half a period before each rise
    task automatic send(input logic [7:0] bits);
        for (int i = 7; i >= 0; i--)
        begin
            DATA_O = bits[i];
            #400 BIT_CLK_O = 1'b1;
            #400 BIT_CLK_O = 1'b0;
        end
        #400 DATA_O = ~bits[0]; // Released line must not keep showing the last bit
    endtask
endmodule

// >>> verif/tmc_mode_ctrl_monitor.sv
// Checker for the mode and pin controller, bound to its top module.
// Assumes the top ports of tmc_mode_ctrl; one clock, reset synchronous low.
module tmc_mode_ctrl_monitor (
    input wire logic       CLK_I, RST_B_I, CONFIG_PORT_SELECT_N_I, FIFO_PORT_SELECT_N_I,
    input wire logic       SYNTH_LOCK_I, STANDBY_EN_O, SYNTH_EN_O, RX_CHAIN_EN_O,
    input wire logic       TX_CHAIN_EN_O, PA_EN_O, PA_CHOKE_EN_O, IQ_PHASE_PLUS_O,
    input wire logic       DATA_OE_O, SDO_OE_O, CONFIG_PORT_ACTIVE_O, FIFO_PORT_ACTIVE_O,
    input wire logic       SYNTH_LOCK_OUTPUT_O, SYNTH_LOCK_OUTPUT_OE_O, INTERRUPT_LINE_A_OE_O,
    input wire logic       INTERRUPT_LINE_B_OE_O, REFERENCE_CLOCK_OUTPUT_OE_O,
    input wire logic [2:0] CHIP_MODE_O
);
    timeunit 1ns;
    timeprecision 1ps;
    // One domain, so clock and reset are given once
    default clocking @(posedge CLK_I); endclocking
    default disable iff (!RST_B_I);
    // Pin and block checks; pins pass three flops, hence the depth of three
    property p_sleep; CHIP_MODE_O == 3'h0 |-> !(STANDBY_EN_O | SYNTH_EN_O | DATA_OE_O
        | INTERRUPT_LINE_A_OE_O | REFERENCE_CLOCK_OUTPUT_OE_O); endproperty
    a_sleep: assert property (p_sleep) else $error("awake output in sleep");
    property p_rx; CHIP_MODE_O == 3'h3 |-> SYNTH_EN_O && RX_CHAIN_EN_O && !TX_CHAIN_EN_O
        && INTERRUPT_LINE_B_OE_O; endproperty
    a_rx: assert property (p_rx) else $error("receive enables wrong");
    property p_tx; CHIP_MODE_O == 3'h4 |-> SYNTH_EN_O && TX_CHAIN_EN_O && !RX_CHAIN_EN_O
        && !DATA_OE_O; endproperty
    a_tx: assert property (p_tx) else $error("transmit enables wrong");
    property p_sdo; SDO_OE_O |-> $past(!(CONFIG_PORT_SELECT_N_I && FIFO_PORT_SELECT_N_I), 3);
    endproperty
    a_sdo: assert property (p_sdo) else $error("serial out driven unselected");
    property p_prio; $past(RST_B_I, 3) && $past(!CONFIG_PORT_SELECT_N_I, 3)
        |-> CONFIG_PORT_ACTIVE_O && !FIFO_PORT_ACTIVE_O; endproperty
    a_prio: assert property (p_prio) else $error("select priority wrong");
    property p_lock; SYNTH_LOCK_OUTPUT_OE_O |-> STANDBY_EN_O
        && SYNTH_LOCK_OUTPUT_O == $past(SYNTH_LOCK_I, 3); endproperty
    a_lock: assert property (p_lock) else $error("lock output wrong");
    property p_pa; !TX_CHAIN_EN_O |-> !(PA_EN_O | PA_CHOKE_EN_O | IQ_PHASE_PLUS_O); endproperty
    a_pa: assert property (p_pa) else $error("amplifier on outside transmit");
    property p_key; PA_EN_O == PA_CHOKE_EN_O && (!IQ_PHASE_PLUS_O || PA_EN_O); endproperty
    a_key: assert property (p_key) else $error("amplifier keying wrong");
endmodule
bind tmc_mode_ctrl tmc_mode_ctrl_monitor u_mon (.*);

// >>> verif/tmc_mode_ctrl_test.sv
// Self-checking bench for the mode and pin controller.
// Assumes a 10 MHz clock; the host model makes the bit clock and data pin.
module tmc_mode_ctrl_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic CLK_I, RST_B_I, CFG_REFERENCE_CLOCK_OUTPUT_EN_I, CFG_LOCK_OUT_EN_I, CFG_OOK_I, CFG_INT_TX_SRC_I;
    logic CFG_IRQ_A_EN_I, CFG_IRQ_A_UNMASK_I, CFG_IRQ_A_HIGH_I, CFG_IRQ_B_EN_I;
    logic CFG_IRQ_B_UNMASK_I, CFG_IRQ_B_HIGH_I, CONFIG_PORT_SELECT_N_I, FIFO_PORT_SELECT_N_I;
    logic SYNTH_LOCK_I, SDO_BIT_I, IRQ_A_EVENT_I, IRQ_B_EVENT_I, DEMOD_BIT_I, DEMOD_VALID_I;
    logic INT_TX_BIT_I, INT_TX_VALID_I, MOD_BIT_STROBE_I, FIFO_IN_READY_O, STANDBY_EN_O;
    logic REFERENCE_CLOCK_OUTPUT_BLOCK_EN_O, SYNTH_EN_O, RX_CHAIN_EN_O, TX_CHAIN_EN_O, PA_EN_O, PA_CHOKE_EN_O;
    logic IQ_PHASE_PLUS_O, SERIAL_DATA_PORT_EN_O, CONFIG_PORT_ACTIVE_O, FIFO_PORT_ACTIVE_O;
    logic SDO_O, SDO_OE_O, INTERRUPT_LINE_A_O, INTERRUPT_LINE_A_OE_O, INTERRUPT_LINE_B_O;
    logic INTERRUPT_LINE_B_OE_O, REFERENCE_CLOCK_OUTPUT_O, REFERENCE_CLOCK_OUTPUT_OE_O;
    logic SYNTH_LOCK_OUTPUT_O, SYNTH_LOCK_OUTPUT_OE_O, DATA_O, DATA_OE_O;
    logic [2:0] CFG_CHIP_MODE_I, CHIP_MODE_O;
    logic [1:0] CFG_DATA_MODE_I;
    logic [7:0] CFG_REFERENCE_CLOCK_OUTPUT_DIV_I, CFG_DEVIATION_I, DEVIATION_VALUE_O;
    wire        BIT_CLK_I, DATA_I;
    int         n_errors, tests_run;
    tmc_mode_ctrl u_dut (.*);
    tmc_host_model u_host (.BIT_CLK_O(BIT_CLK_I), .DATA_O(DATA_I));
    // Clock; inputs settle at time zero with both selects idle high
    always #50 CLK_I = ~CLK_I;
    initial
    begin
        {CLK_I, RST_B_I, CFG_LOCK_OUT_EN_I, CFG_OOK_I, CFG_INT_TX_SRC_I, CFG_IRQ_A_EN_I,
         CFG_IRQ_A_UNMASK_I, CFG_IRQ_A_HIGH_I, CFG_IRQ_B_EN_I, CFG_IRQ_B_UNMASK_I,
         CFG_IRQ_B_HIGH_I, SYNTH_LOCK_I, SDO_BIT_I, IRQ_A_EVENT_I, IRQ_B_EVENT_I,
         DEMOD_BIT_I, DEMOD_VALID_I, INT_TX_BIT_I, INT_TX_VALID_I, MOD_BIT_STROBE_I,
         CFG_CHIP_MODE_I, CFG_DATA_MODE_I, CFG_REFERENCE_CLOCK_OUTPUT_DIV_I, CFG_DEVIATION_I} = '0;
        {CFG_REFERENCE_CLOCK_OUTPUT_EN_I, CONFIG_PORT_SELECT_N_I, FIFO_PORT_SELECT_N_I} = 3'h7;
    end
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // Staged fields only load on the rising edge of the config select
    task automatic apply();
        @(posedge CLK_I) CONFIG_PORT_SELECT_N_I <= 1'b0;
        repeat (3) @(posedge CLK_I);
        CONFIG_PORT_SELECT_N_I <= 1'b1;
        repeat (6) @(posedge CLK_I);
        #1;
    endtask
    // Modulator takes one bit; outputs land two edges after the strobe is driven
    task automatic take_bit();
        @(posedge CLK_I) MOD_BIT_STROBE_I <= 1'b1;
        @(posedge CLK_I) MOD_BIT_STROBE_I <= 1'b0;
        repeat (2) @(posedge CLK_I);
        #1;
    endtask
    task automatic t_modes();
        check(FIFO_IN_READY_O, 1'b1);
        check(STANDBY_EN_O, 1'b0);
        for (int m = 0; m < 5; m++)
        begin
            CFG_CHIP_MODE_I <= m[2:0];
            apply();
            check(CHIP_MODE_O, m[2:0]);
            check(STANDBY_EN_O, m != 0);
            check({REFERENCE_CLOCK_OUTPUT_OE_O, REFERENCE_CLOCK_OUTPUT_BLOCK_EN_O}, {2{m != 0}});
            check(SYNTH_EN_O, m >= 2);
            check(RX_CHAIN_EN_O, m == 3);
            check({TX_CHAIN_EN_O, DATA_OE_O}, {m == 4, m == 3});
            check(INTERRUPT_LINE_A_OE_O, m >= 3);
        end
        $display("modes test done");
    endtask
    task automatic t_select();
        CFG_CHIP_MODE_I <= 3'h1;
        CFG_DATA_MODE_I <= 2'h1;
        apply();
        check({INTERRUPT_LINE_B_OE_O, SERIAL_DATA_PORT_EN_O}, 2'h3);
        @(posedge CLK_I) FIFO_PORT_SELECT_N_I <= 1'b0;
        SDO_BIT_I <= 1'b1;
        repeat (4) @(posedge CLK_I);
        #1 check({FIFO_PORT_ACTIVE_O, SDO_OE_O, SDO_O}, 3'h7);
        @(posedge CLK_I) CONFIG_PORT_SELECT_N_I <= 1'b0;
        repeat (4) @(posedge CLK_I);
        #1 check({CONFIG_PORT_ACTIVE_O, FIFO_PORT_ACTIVE_O}, 2'h2);
        @(posedge CLK_I) {CONFIG_PORT_SELECT_N_I, FIFO_PORT_SELECT_N_I} <= 2'h3;
        repeat (4) @(posedge CLK_I);
        #1 check(SDO_OE_O, 1'b0);
        $display("select test done");
    endtask
    task automatic t_irq_lock();
        {CFG_IRQ_A_EN_I, CFG_IRQ_A_UNMASK_I, CFG_IRQ_A_HIGH_I, CFG_IRQ_B_EN_I} <= 4'hf;
        {CFG_LOCK_OUT_EN_I, SYNTH_LOCK_I} <= 2'h3;
        apply();
        check({INTERRUPT_LINE_A_O, INTERRUPT_LINE_B_O}, 2'h1);
        {IRQ_A_EVENT_I, IRQ_B_EVENT_I} <= 2'h3;
        repeat (2) @(posedge CLK_I);
        #1 check({INTERRUPT_LINE_A_O, INTERRUPT_LINE_B_O}, 2'h3);
        check({SYNTH_LOCK_OUTPUT_OE_O, SYNTH_LOCK_OUTPUT_O}, 2'h3);
        $display("interrupt and lock test done");
    endtask
    task automatic t_tx();
        logic [7:0] pat;
        pat = 8'hb2;
        {CFG_CHIP_MODE_I, CFG_DATA_MODE_I, CFG_INT_TX_SRC_I, CFG_OOK_I} <= {3'h4, 4'h0};
        apply();
        u_host.send(pat);
        for (int i = 7; i >= 0; i--)
        begin
            take_bit();
            check({IQ_PHASE_PLUS_O, PA_EN_O}, {pat[i], 1'b1});
        end
        {CFG_DATA_MODE_I, CFG_INT_TX_SRC_I, CFG_OOK_I, CFG_DEVIATION_I} <= {4'h7, 8'h5a};
        apply();
        check(DEVIATION_VALUE_O, 8'h5a);
        CFG_DEVIATION_I <= 8'h33;
        for (int i = 2; i >= 0; i--)
        begin
            @(posedge CLK_I) {INT_TX_VALID_I, INT_TX_BIT_I} <= {1'b1, pat[i]};
        end
        @(posedge CLK_I) INT_TX_VALID_I <= 1'b0;
        for (int i = 2; i >= 0; i--)
        begin
            take_bit();
            check({IQ_PHASE_PLUS_O, PA_EN_O, PA_CHOKE_EN_O}, {1'b0, pat[i], pat[i]});
        end
        check(DEVIATION_VALUE_O, 8'h5a);
        {CFG_CHIP_MODE_I, CFG_DATA_MODE_I} <= 5'h0c;
        apply();
        {DEMOD_VALID_I, DEMOD_BIT_I} <= 2'h3;
        @(posedge CLK_I) DEMOD_VALID_I <= 1'b0;
        u_host.send(8'h01);
        check({DATA_OE_O, DATA_O}, 2'h3);
        $display("transmit test done");
    endtask
    // Watchdog allows about sixty-five times the expected run
    initial
    begin
        #2000000;
        n_errors++;
        print_verdict();
    end
    initial
    begin
        repeat (6) @(posedge CLK_I);
        RST_B_I <= 1'b1;
        @(posedge CLK_I) #1;
        t_modes();
        t_select();
        t_irq_lock();
        t_tx();
        print_verdict();
    end
endmodule
